// file: hw/scn_bank.v
// Bank of scan-evaluated delay timers, fast timers and counters.
//
// Strobed register access and the register addresses were left to the implementer.
`include "scn_defines.vh"
module scn_bank #(
    parameter NUM_INST = `SCN_NUM_INST,
    parameter INST_W = 9,
    parameter FAST_TICK_CYCLES = `SCN_FAST_BASE_NS / `SCN_CLK_PERIOD_NS
) (
    input wire clock,
    input wire reset,
    input wire [INST_W+1:0] address,
    input wire [15:0] write_data,
    input wire write_strobe,
    input wire read_strobe,
    output reg [15:0] read_data_q,
    input wire power_lost,
    input wire irq_update_mode,
    output reg error_flag_q,
    output reg [NUM_INST-1:0] completion_q
);
    localparam [INST_W:0] NUM_W = NUM_INST;
    localparam [31:0] TICK_LAST = FAST_TICK_CYCLES - 1;

    reg [15:0] sv_q [0:NUM_INST-1];
    reg [15:0] pv_q [0:NUM_INST-1];
    reg [1:0] func_q [0:NUM_INST-1];
    reg [NUM_INST-1:0] prev_a_q;
    reg [NUM_INST-1:0] prev_b_q;
    reg [NUM_INST-1:0] prev_r_q;
    reg [NUM_INST-1:0] run_q;
    reg [NUM_INST-1:0] owed_q;
    reg [31:0] tick_cnt_q;
    reg [3:0] slow_div_q;
    reg fast_tick_q;
    reg slow_tick_q;
    reg pwr_meta_q;
    reg pwr_sync_q;
    reg pwr_prev_q;
    reg irq_meta_q;
    reg irq_sync_q;
    reg [3:0] sweep_q;
    integer k;

    // Decode of the register port.
    wire [INST_W-1:0] inst = address[INST_W+1:2];
    wire [1:0] reg_sel = address[1:0];
    wire in_range = ({1'b0, inst} < NUM_W);
    wire wr_hit = write_strobe & in_range;
    wire eval = wr_hit & (reg_sel == `SCN_REG_CMD) &
        write_data[`SCN_CMD_EVAL];
    wire in_a = write_data[`SCN_CMD_IN_A];
    wire in_b = write_data[`SCN_CMD_IN_B];
    wire in_r = write_data[`SCN_CMD_RESET];
    wire il_off = write_data[`SCN_CMD_IL_OFF];
    wire skip = write_data[`SCN_CMD_SKIP];
    wire skip00 = write_data[`SCN_CMD_SKIP00];
    wire ind_bad = write_data[`SCN_CMD_IND_BAD];
    wire clr_err = wr_hit & (reg_sel == `SCN_REG_CMD) &
        write_data[`SCN_CMD_CLR_ERR];

    wire [1:0] e_func = func_q[inst];
    wire [15:0] e_sv = sv_q[inst];
    wire [15:0] e_pv = pv_q[inst];
    wire is_timer = (e_func == `SCN_FUNC_DELAY) |
        (e_func == `SCN_FUNC_FAST);
    wire e_run = run_q[inst];
    wire e_owed = owed_q[inst];

    // Arithmetic on the evaluated instance.
    wire sv_ok;
    wire sv_zero;
    wire pv_zero;
    wire [15:0] pv_inc;
    wire [15:0] pv_dec;
    scn_bcd_step u_sv (
        .value(e_sv),
        .valid(sv_ok),
        .is_zero(sv_zero),
        .plus_one(),
        .minus_one()
    );
    scn_bcd_step u_pv (
        .value(e_pv),
        .valid(),
        .is_zero(pv_zero),
        .plus_one(pv_inc),
        .minus_one(pv_dec)
    );

    // Arithmetic on the fast timer visited by the interrupt sweep.
    wire [INST_W-1:0] sw_idx = {{(INST_W-4){1'b0}}, sweep_q};
    wire [15:0] sw_pv = pv_q[sw_idx];
    wire [15:0] sw_dec;
    wire sw_zero;
    scn_bcd_step u_sweep (
        .value(sw_pv),
        .valid(),
        .is_zero(sw_zero),
        .plus_one(),
        .minus_one(sw_dec)
    );

    // A timing step is taken when a running timer owes a tick.
    wire eval_cons = eval & is_timer & ~il_off & e_run & e_owed &
        (skip ? ~skip00 : in_a);
    wire tim_clr = eval & is_timer & (eval_cons | ~e_run);
    wire sweep_cons = irq_sync_q & ~eval &
        (func_q[sw_idx] == `SCN_FUNC_FAST) & run_q[sw_idx] &
        owed_q[sw_idx];
    wire pwr_rst = pwr_sync_q & ~pwr_prev_q;

    // Counter edges against the inputs stored at the last evaluation.
    wire rise_a = in_a & ~prev_a_q[inst];
    wire rise_b = in_b & ~prev_b_q[inst];
    wire rise_r = in_r & ~prev_r_q[inst];

    // Synchronisers for the two pins and edge memory for power loss.
    always @(posedge clock) begin
        if (reset) begin
            pwr_meta_q <= 1'b0;
            pwr_sync_q <= 1'b0;
            pwr_prev_q <= 1'b0;
            irq_meta_q <= 1'b0;
            irq_sync_q <= 1'b0;
        end else begin
            pwr_meta_q <= power_lost;
            pwr_sync_q <= pwr_meta_q;
            pwr_prev_q <= pwr_sync_q;
            irq_meta_q <= irq_update_mode;
            irq_sync_q <= irq_meta_q;
        end
    end

    // Time base: 0.01 s enable pulse and a tenfold 0.1 s pulse.
    always @(posedge clock) begin
        if (reset) begin
            tick_cnt_q <= 32'h00000000;
            slow_div_q <= 4'h0;
            fast_tick_q <= 1'b0;
            slow_tick_q <= 1'b0;
        end else begin
            fast_tick_q <= 1'b0;
            slow_tick_q <= 1'b0;
            if (tick_cnt_q >= TICK_LAST) begin
                tick_cnt_q <= 32'h00000000;
                fast_tick_q <= 1'b1;
                if (slow_div_q == `SCN_SLOW_PER_FAST) begin
                    slow_div_q <= 4'h0;
                    slow_tick_q <= 1'b1;
                end else begin
                    slow_div_q <= slow_div_q + 4'h1;
                end
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h00000001;
            end
        end
    end

    // Sweep pointer over the interrupt-updated fast timers.
    always @(posedge clock) begin
        if (reset) begin
            sweep_q <= 4'h0;
        end else if (~eval) begin
            sweep_q <= (sweep_q == `SCN_IRQ_INST) ? 4'h0 :
                sweep_q + 4'h1;
        end
    end

    // Owed-tick bit per instance; a new tick wins over a clear.
    genvar i;
    generate
        for (i = 0; i < NUM_INST; i = i + 1) begin : g_owed
            wire tick_i = ((func_q[i] == `SCN_FUNC_DELAY) & slow_tick_q) |
                ((func_q[i] == `SCN_FUNC_FAST) & fast_tick_q);
            wire clr_i = (tim_clr & (inst == i)) |
                (sweep_cons & (sw_idx == i));
            always @(posedge clock) begin
                if (reset) begin
                    owed_q[i] <= 1'b0;
                end else if (tick_i & run_q[i]) begin
                    owed_q[i] <= 1'b1;
                end else if (clr_i | pwr_rst) begin
                    owed_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Register writes, scan evaluation and timer reset by power loss.
    always @(posedge clock) begin
        if (reset) begin
            for (k = 0; k < NUM_INST; k = k + 1) begin
                sv_q[k] <= `SCN_SV_RESET;
                pv_q[k] <= `SCN_PV_RESET;
                func_q[k] <= `SCN_FUNC_DELAY;
            end
            prev_a_q <= {NUM_INST{1'b0}};
            prev_b_q <= {NUM_INST{1'b0}};
            prev_r_q <= {NUM_INST{1'b0}};
            run_q <= {NUM_INST{1'b0}};
            completion_q <= {NUM_INST{1'b0}};
            error_flag_q <= 1'b0;
        end else begin
            if (pwr_rst) begin
                for (k = 0; k < NUM_INST; k = k + 1) begin
                    if (func_q[k] == `SCN_FUNC_DELAY ||
                        func_q[k] == `SCN_FUNC_FAST) begin
                        pv_q[k] <= sv_q[k];
                        completion_q[k] <= 1'b0;
                        run_q[k] <= 1'b0;
                        prev_a_q[k] <= 1'b0;
                    end
                end
            end
            if (wr_hit && reg_sel == `SCN_REG_SV) begin
                sv_q[inst] <= write_data;
            end
            if (wr_hit && reg_sel == `SCN_REG_CFG) begin
                func_q[inst] <= write_data[1:0];
            end
            if (sweep_cons) begin
                pv_q[sw_idx] <= sw_dec;
                if (sw_dec == 16'h0000) begin
                    completion_q[sw_idx] <= 1'b1;
                    run_q[sw_idx] <= 1'b0;
                end
            end
            if ((eval && (~sv_ok || ind_bad)) || sweep_q == 4'hF &&
                1'b0) begin
                error_flag_q <= 1'b1;
            end else if (clr_err) begin
                error_flag_q <= 1'b0;
            end
            if (eval && is_timer) begin
                if (il_off) begin
                    pv_q[inst] <= e_sv;
                    completion_q[inst] <= 1'b0;
                    run_q[inst] <= 1'b0;
                    prev_a_q[inst] <= 1'b0;
                end else if (skip) begin
                    if (eval_cons) begin
                        pv_q[inst] <= pv_dec;
                        if (pv_dec == 16'h0000) begin
                            completion_q[inst] <= 1'b1;
                            run_q[inst] <= 1'b0;
                        end
                    end
                end else if (~in_a) begin
                    pv_q[inst] <= e_sv;
                    completion_q[inst] <= 1'b0;
                    run_q[inst] <= 1'b0;
                    prev_a_q[inst] <= 1'b0;
                end else if (~prev_a_q[inst]) begin
                    pv_q[inst] <= e_sv;
                    completion_q[inst] <= sv_zero;
                    run_q[inst] <= ~sv_zero;
                    prev_a_q[inst] <= 1'b1;
                end else if (eval_cons) begin
                    pv_q[inst] <= pv_dec;
                    if (pv_dec == 16'h0000) begin
                        completion_q[inst] <= 1'b1;
                        run_q[inst] <= 1'b0;
                    end
                end
            end
            if (eval && ~il_off && ~skip &&
                e_func == `SCN_FUNC_DOWN) begin
                prev_a_q[inst] <= in_a;
                prev_r_q[inst] <= in_r;
                if (in_r) begin
                    if (rise_r) begin
                        pv_q[inst] <= e_sv;
                        completion_q[inst] <= sv_zero;
                    end
                end else if (rise_a && ~pv_zero) begin
                    pv_q[inst] <= pv_dec;
                    if (pv_dec == 16'h0000) begin
                        completion_q[inst] <= 1'b1;
                    end
                end
            end
            if (eval && ~il_off && ~skip &&
                e_func == `SCN_FUNC_WRAP) begin
                prev_a_q[inst] <= in_a;
                prev_b_q[inst] <= in_b;
                prev_r_q[inst] <= in_r;
                if (in_r) begin
                    if (rise_r) begin
                        pv_q[inst] <= 16'h0000;
                        completion_q[inst] <= 1'b0;
                    end
                end else if (rise_a && rise_b) begin
                    pv_q[inst] <= e_pv;
                end else if (rise_a) begin
                    if (e_pv == e_sv) begin
                        pv_q[inst] <= 16'h0000;
                        completion_q[inst] <= 1'b1;
                    end else begin
                        pv_q[inst] <= pv_inc;
                        completion_q[inst] <= 1'b0;
                    end
                end else if (rise_b) begin
                    if (pv_zero) begin
                        pv_q[inst] <= e_sv;
                        completion_q[inst] <= 1'b1;
                    end else begin
                        pv_q[inst] <= pv_dec;
                        completion_q[inst] <= 1'b0;
                    end
                end
            end
        end
    end

    // Read data stands for the one cycle after the read strobe.
    always @(posedge clock) begin
        if (reset) begin
            read_data_q <= 16'h0000;
        end else if (read_strobe && in_range) begin
            case (reg_sel)
                `SCN_REG_SV: read_data_q <= e_sv;
                `SCN_REG_PV: read_data_q <= e_pv;
                `SCN_REG_CFG: read_data_q <= {14'h0000, e_func};
                default: read_data_q <= {14'h0000, error_flag_q,
                    completion_q[inst]};
            endcase
        end else begin
            read_data_q <= 16'h0000;
        end
    end
endmodule

// file: hw/scn_defines.vh
// Constants for the scan-evaluated timer and counter bank.
// Functional notes
// - Delay timer starts on condition, reloads when off.
// - Delay timer counts down every 0.1 s.
// - Zero with condition on sets held completion.
// - Set value zero completes immediately on start.
// - Bad BCD or bad indirect word sets error.
// - Down counter decrements on count input rise.
// - Down counter completes at zero, holds till reset.
// - Reset rise reloads down counter, blocks counting.
// - Down counter value survives interlock and power.
// - Wrap counter adds one on increment rise.
// - Wrap counter subtracts one on decrement rise.
// - Both rises together leave value unchanged.
// - Decrement from zero wraps to set value, completes.
// - Increment past set value wraps to zero, completes.
// - Reset rise clears wrap counter, blocks counting.
// - Wrap counter value survives interlock and power.
// - Fast timer counts down every 0.01 s.
// - Skipped timers keep timing unless jump 00.
// - One shared number space 000 to 511.
`ifndef SCN_DEFINES_VH
`define SCN_DEFINES_VH
`define SCN_CLK_PERIOD_NS 10
`define SCN_FAST_BASE_NS 10000000
`define SCN_SLOW_PER_FAST 4'h9
`define SCN_NUM_INST 512
`define SCN_IRQ_INST 4'hF
`define SCN_REG_SV 2'h0
`define SCN_REG_PV 2'h1
`define SCN_REG_CFG 2'h2
`define SCN_REG_CMD 2'h3
`define SCN_FUNC_DELAY 2'h0
`define SCN_FUNC_FAST 2'h1
`define SCN_FUNC_DOWN 2'h2
`define SCN_FUNC_WRAP 2'h3
`define SCN_CMD_IN_A 0
`define SCN_CMD_IN_B 1
`define SCN_CMD_RESET 2
`define SCN_CMD_IL_OFF 3
`define SCN_CMD_SKIP 4
`define SCN_CMD_SKIP00 5
`define SCN_CMD_IND_BAD 6
`define SCN_CMD_CLR_ERR 7
`define SCN_CMD_EVAL 8
`define SCN_SV_RESET 16'h0000
`define SCN_PV_RESET 16'h0000
`endif

// file: hw/scn_bcd_step.v
// Four-digit BCD check, increment, decrement and zero test.
module scn_bcd_step (
    input wire [15:0] value,
    output wire valid,
    output wire is_zero,
    output wire [15:0] plus_one,
    output wire [15:0] minus_one
);
    wire [4:0] carry;
    wire [4:0] borrow;
    wire [3:0] dig_ok;

    assign carry[0] = 1'b1;
    assign borrow[0] = 1'b1;

    // Each digit ripples its carry and borrow into the next one.
    genvar d;
    generate
        for (d = 0; d < 4; d = d + 1) begin : g_digit
            wire [3:0] dig = value[4*d+3:4*d];
            wire top = (dig == 4'h9);
            wire bot = (dig == 4'h0);
            assign dig_ok[d] = (dig <= 4'h9);
            assign carry[d+1] = carry[d] & top;
            assign borrow[d+1] = borrow[d] & bot;
            assign plus_one[4*d+3:4*d] = carry[d] ?
                (top ? 4'h0 : dig + 4'h1) : dig;
            assign minus_one[4*d+3:4*d] = borrow[d] ?
                (bot ? 4'h9 : dig - 4'h1) : dig;
        end
    endgenerate

    assign valid = &dig_ok;
    assign is_zero = (value == 16'h0000);
endmodule

// file: dv/scn_bank_properties.sv
// Port checker for the scan-evaluated timer and counter bank.
module scn_bank_properties #(
    parameter NUM_INST = 512,
    parameter INST_W = 9
) (
    input wire clock,
    input wire reset,
    input wire [INST_W+1:0] address,
    input wire [15:0] write_data,
    input wire write_strobe,
    input wire read_strobe,
    input wire [15:0] read_data_q,
    input wire power_lost,
    input wire irq_update_mode,
    input wire error_flag_q,
    input wire [NUM_INST-1:0] completion_q
);
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (reset);
    // Decoded request and a shadow of each instance's function and value.
    logic [1:0] fn_q [NUM_INST];
    logic [15:0] sv_q [NUM_INST];
    wire [INST_W-1:0] n = address[INST_W+1:2];
    wire cmd = write_strobe && address[1:0] == 2'h3;
    wire scan = cmd && write_data[8];
    wire quiet = !irq_update_mode && !power_lost;
    wire tmr = fn_q[n] < 2'h2;
    // The shadow follows set value and function writes.
    always_ff @(posedge clock) begin
        for (int i = 0; i < NUM_INST; i++) begin
            if (reset) begin
                fn_q[i] <= 2'h0;
                sv_q[i] <= 16'h0000;
            end else if (write_strobe && n == INST_W'(i)) begin
                sv_q[i] <= (address[1:0] == 2'h0) ? write_data : sv_q[i];
                fn_q[i] <= (address[1:0] == 2'h2) ? write_data[1:0] : fn_q[i];
            end
        end
    end
    a_read_idle_zero: assert property (
        !$past(read_strobe) |-> read_data_q == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_reset_clears: assert property (disable iff (1'b0) reset |=>
        read_data_q == 16'h0000 && !error_flag_q && completion_q == '0)
        else $error("reset left an output set");
    a_error_sticky: assert property (
        error_flag_q && !(cmd && write_data[7]) |=> error_flag_q)
        else $error("error flag dropped without a clear");
    a_error_cause: assert property (
        $rose(error_flag_q) && !irq_update_mode |-> $past(scan))
        else $error("error flag rose without an evaluation");
    a_status_word: assert property (read_strobe && address[1:0] == 2'h3
        && quiet |=> read_data_q ==
        {14'h0000, $past(error_flag_q), $past(completion_q[n])})
        else $error("status read does not match the flags");
    a_comp_quiet: assert property (!$past(scan) && !$past(reset) && quiet
        && !$past(power_lost, 4) |-> $stable(completion_q))
        else $error("completion changed without an evaluation");
    a_zero_sv_done: assert property (scan && write_data[0] && tmr
        && !write_data[3] && !write_data[4] && sv_q[n] == 16'h0000
        && quiet |=> completion_q[$past(n)])
        else $error("zero set value did not complete at once");
    a_timer_off: assert property (scan && (!write_data[0] || write_data[3])
        && !write_data[4] && tmr && quiet |=> !completion_q[$past(n)])
        else $error("timer kept completion while reset");
    a_count_held: assert property (scan && fn_q[n] == 2'h2 && quiet
        && completion_q[n] && !write_data[2] |=> completion_q[$past(n)])
        else $error("down counter lost completion without reset");
endmodule
bind scn_bank scn_bank_properties #(
    .NUM_INST(NUM_INST),
    .INST_W(INST_W)
) i_scn_bank_properties (
    .clock(clock), .reset(reset), .address(address),
    .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data_q(read_data_q),
    .power_lost(power_lost), .irq_update_mode(irq_update_mode),
    .error_flag_q(error_flag_q), .completion_q(completion_q));

// file: dv/scn_scan_model.sv
// Program-scan model that drives the bank's register port.
module scn_scan_model #(
    parameter INST_W = 9
) (
    input wire clock,
    input wire [15:0] read_data_q,
    output logic [INST_W+1:0] address,
    output logic [15:0] write_data,
    output logic write_strobe,
    output logic read_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    // The port is idle from time zero.
    initial begin
        address = '0;
        write_data = 16'h0000;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
    end
    // One write cycle, then an idle cycle so strobes never merge.
    task automatic wr(input logic [INST_W-1:0] n, input logic [1:0] r,
                      input logic [15:0] v);
        address <= {n, r};
        write_data <= v;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
        @(posedge clock);
    endtask
    // One read cycle; the answer is taken in the cycle after it.
    task automatic rd(input logic [INST_W-1:0] n, input logic [1:0] r,
                      output logic [15:0] v);
        address <= {n, r};
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        @(posedge clock);
        v = read_data_q;
    endtask
    // Loads a BCD set value and a function into an instance.
    task automatic setup(input logic [INST_W-1:0] n, input logic [1:0] f,
                         input logic [15:0] sv);
        wr(n, 2'h0, sv);
        wr(n, 2'h2, {14'h0000, f});
    endtask
    // One scan of an instance with the given execution conditions.
    task automatic scan(input logic [INST_W-1:0] n, input logic [7:0] c);
        wr(n, 2'h3, {8'h01, c});
    endtask
endmodule

// file: dv/tb.sv
// Self-checking bench for the timer and counter bank.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic power_lost = 1'b0;
    logic irq_update_mode = 1'b0;
    logic [10:0] address;
    logic [15:0] write_data;
    logic [15:0] read_data_q;
    logic write_strobe;
    logic read_strobe;
    logic error_flag_q;
    logic [511:0] completion_q;
    logic [15:0] d;
    int n_errors = 0;
    int check_count = 0;
    // Rows: instance, inputs {il_off, reset, dec, inc}, PV, completion.
    logic [23:0] rows [0:38] = '{
        24'h144000, 24'h140000, 24'h141010, 24'h140010, 24'h141020,
        24'h140020, 24'h141001, 24'h140001, 24'h142021, 24'h140021,
        24'h142010, 24'h140010, 24'h143010, 24'h140010, 24'h149010,
        24'h140010, 24'h144000, 24'h145000, 24'h141000, 24'h140000,
        24'h141010, 24'h154030, 24'h150030, 24'h151020, 24'h151020,
        24'h150020, 24'h151010, 24'h150010, 24'h151001, 24'h150001,
        24'h154030, 24'h155030, 24'h1E1001, 24'h1E0000, 24'h1E1001,
        24'h1E9000, 24'h1E1001, 24'h1F1050, 24'h1F0050};
    scn_bank #(.FAST_TICK_CYCLES(20)) i_scn_bank (
        .clock(clock), .reset(reset), .address(address),
        .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data_q(read_data_q),
        .power_lost(power_lost), .irq_update_mode(irq_update_mode),
        .error_flag_q(error_flag_q), .completion_q(completion_q));
    scn_scan_model prog (
        .clock(clock), .read_data_q(read_data_q), .address(address),
        .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe));
    // The clock runs at 100 MHz.
    initial begin
        forever #5 clock = ~clock;
    end
    // Counts a comparison and reports a difference at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Loads a timer and starts it with a rising execution condition.
    task automatic start(input logic [8:0] n, input logic [1:0] f,
                         input logic [15:0] sv);
        prog.setup(n, f, sv);
        prog.scan(n, 8'h00);
        prog.scan(n, 8'h01);
    endtask
    // Scans a running timer until it completes; checks time and hold.
    task automatic finish(input logic [8:0] n, input logic [7:0] c,
                          input int lo, input int hi);
        int k;
        for (k = 0; k < 300; k++) begin
            if (completion_q[n] === 1'b1) begin
                break;
            end
            prog.scan(n, c);
        end
        if (k == 300) begin
            n_errors++;
            conclude();
        end
        check({15'h0000, 2 * k >= lo && 2 * k <= hi}, 16'h0001);
        prog.scan(n, c);
        prog.rd(n, 2'h3, d);
        check(d, 16'h0001);
        prog.rd(n, 2'h1, d);
        check(d, 16'h0000);
    endtask
    // Main sequence: table of scans first, then the awkward cases.
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        prog.setup(9'h014, 2'h3, 16'h0002);
        prog.setup(9'h015, 2'h2, 16'h0003);
        prog.setup(9'h01E, 2'h0, 16'h0000);
        prog.setup(9'h01F, 2'h0, 16'h0005);
        foreach (rows[i]) begin
            prog.scan({1'b0, rows[i][23:16]}, {4'h0, rows[i][15:12]});
            prog.rd({1'b0, rows[i][23:16]}, 2'h1, d);
            check(d, {8'h00, rows[i][11:4]});
            prog.rd({1'b0, rows[i][23:16]}, 2'h3, d);
            check(d, {12'h000, rows[i][3:0]});
        end
        $display("done scan table");
        prog.wr(9'h015, 2'h1, 16'h0009);
        prog.rd(9'h015, 2'h1, d);
        check(d, 16'h0003);
        power_lost <= 1'b1;
        repeat (6) @(posedge clock);
        power_lost <= 1'b0;
        repeat (2) @(posedge clock);
        check({15'h0000, completion_q[30]}, 16'h0000);
        prog.rd(9'h015, 2'h1, d);
        check(d, 16'h0003);
        prog.rd(9'h014, 2'h1, d);
        check(d, 16'h0001);
        $display("done power loss");
        prog.wr(9'h028, 2'h0, 16'h00A0);
        prog.scan(9'h028, 8'h01);
        check({15'h0000, error_flag_q}, 16'h0001);
        prog.wr(9'h028, 2'h3, 16'h0080);
        check({15'h0000, error_flag_q}, 16'h0000);
        prog.scan(9'h029, 8'h40);
        prog.rd(9'h029, 2'h3, d);
        check(d & 16'h0002, 16'h0002);
        prog.wr(9'h029, 2'h3, 16'h0080);
        $display("done error flag");
        start(9'h03C, 2'h1, 16'h0003);
        finish(9'h03C, 8'h01, 36, 66);
        start(9'h03D, 2'h0, 16'h0002);
        finish(9'h03D, 8'h01, 196, 406);
        start(9'h032, 2'h1, 16'h0003);
        repeat (40) prog.scan(9'h032, 8'h31);
        prog.rd(9'h032, 2'h1, d);
        check(d, 16'h0003);
        finish(9'h032, 8'h11, 16, 66);
        irq_update_mode <= 1'b1;
        start(9'h005, 2'h1, 16'h0003);
        repeat (100) @(posedge clock);
        check({15'h0000, completion_q[5]}, 16'h0001);
        irq_update_mode <= 1'b0;
        $display("done timers");
        conclude();
    end
endmodule
